// ### aom_core.sv
// add-only memory: staged, checked, pulse-committed writes and checked reads
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/10ps
module aom_core
  import aom_pkg::*;
#(
  parameter int PAGES        = AOM_PAGES_SMALL,
  parameter int STATUS_BYTES = AOM_STATUS_SMALL,
  parameter int PROG_CYCLES  = AOM_PROG_CYCLES,
  parameter int FIFO_DEPTH   = AOM_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  // register port
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [31:0] i_reg_wdata,
  input  wire logic        i_reg_write,
  input  wire logic        i_reg_read,
  output logic [31:0]      o_reg_rdata,
  // link bytes from the master
  input  wire logic        i_rx_valid,
  input  wire logic [7:0]  i_rx_data,
  output logic             o_rx_ready,
  // link bytes to the master
  output logic             o_tx_valid,
  output logic [7:0]       o_tx_data,
  input  wire logic        i_tx_ready,
  // programming pulse pin
  input  wire logic        i_prog_pin
);
  localparam int DATA_BYTES = PAGES * AOM_PAGE_BYTES;
  localparam int WP_BYTES   = (PAGES + 7) / 8;
  localparam int RDR_BASE   = AOM_WP_BASE + WP_BYTES;
  localparam int PCW        = $clog2(PROG_CYCLES + 1);

  // ---------------------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------------------
  logic [7:0] data_mem [DATA_BYTES];
  logic [7:0] stat_mem [STATUS_BYTES];

  initial begin
    for (int i = 0; i < DATA_BYTES; i++) begin
      data_mem[i] = AOM_ERASED;
    end
    for (int i = 0; i < STATUS_BYTES; i++) begin
      stat_mem[i] = AOM_ERASED;
    end
  end

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  aom_state_type  state, next_state;
  aom_sticky_type sticky, next_sticky, sticky_set;
  logic [7:0]     cmd, next_cmd;
  logic [15:0]    addr, next_addr;
  logic [7:0]     stage, next_stage;
  logic [7:0]     crc, next_crc;
  logic [7:0]     last_crc, next_last_crc;
  logic           tx_valid, next_tx_valid;
  logic [7:0]     tx_data, next_tx_data;
  logic           rdr_first, next_rdr_first;
  logic           rd_last, next_rd_last;
  logic [PCW-1:0] pcnt, next_pcnt;
  logic           ctrl_enable, next_ctrl_enable;
  logic [31:0]    rdata, next_rdata;
  logic           prog_s1, prog_s2, prog_s3;
  logic           prog_level, next_prog_level;

  logic           fifo_valid;
  logic [7:0]     fifo_data;
  logic           fifo_take;
  logic           tx_take;
  logic           is_status;
  logic           is_write;
  logic           in_range;
  logic           prot;
  logic           region_end;
  logic [7:0]     cur_byte;
  logic [7:0]     rdr_byte;
  logic           mem_we;
  logic           stat_we;
  logic [7:0]     prog_byte;
  int             a_idx;
  int             pg;

  aom_fifo #(
    .WIDTH (AOM_BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .i_clk       (i_clk),
    .i_reset_n   (i_reset_n),
    .i_in_valid  (i_rx_valid),
    .i_in_data   (i_rx_data),
    .o_in_ready  (o_rx_ready),
    .o_out_valid (fifo_valid),
    .o_out_data  (fifo_data),
    .i_out_ready (fifo_take)
  );

  // ---------------------------------------------------------------------------
  // target decode and protection
  // ---------------------------------------------------------------------------
  always_comb begin
    a_idx      = int'(addr);
    is_status  = (cmd == AOM_CMD_WRITE_STAT) || (cmd == AOM_CMD_READ_STAT);
    is_write   = (cmd == AOM_CMD_WRITE_MEM) || (cmd == AOM_CMD_WRITE_STAT);
    in_range   = is_status ? (a_idx < STATUS_BYTES) : (a_idx < DATA_BYTES);
    cur_byte   = is_status ? stat_mem[a_idx % STATUS_BYTES] : data_mem[a_idx % DATA_BYTES];
    region_end = (addr[4:0] == 5'h1f) || (is_status && (a_idx == STATUS_BYTES - 1));
    pg         = -1;
    if (!is_status) begin
      pg = (a_idx % DATA_BYTES) / AOM_PAGE_BYTES;
    end else if ((a_idx >= RDR_BASE) && (a_idx < RDR_BASE + PAGES)) begin
      pg = a_idx - RDR_BASE;
    end
    // protected when the page's bit has been programmed low
    prot = 1'b0;
    if (pg >= 0) begin
      prot = !stat_mem[AOM_WP_BASE + pg / 8][pg % 8];
    end
    rdr_byte  = stat_mem[(RDR_BASE + (a_idx % DATA_BYTES) / AOM_PAGE_BYTES) % STATUS_BYTES];
    prog_byte = cur_byte & stage;
  end

  // ---------------------------------------------------------------------------
  // command engine
  // ---------------------------------------------------------------------------
  always_comb begin
    next_state     = state;
    next_cmd       = cmd;
    next_addr      = addr;
    next_stage     = stage;
    next_crc       = crc;
    next_last_crc  = last_crc;
    next_tx_valid  = tx_valid;
    next_tx_data   = tx_data;
    next_rdr_first = rdr_first;
    next_rd_last   = rd_last;
    next_pcnt      = pcnt;
    sticky_set     = '0;
    fifo_take      = 1'b0;
    mem_we         = 1'b0;
    stat_we        = 1'b0;
    tx_take        = tx_valid && i_tx_ready;
    case (state)
      AOM_IDLE: begin
        if (fifo_valid) begin
          fifo_take    = 1'b1;
          next_cmd     = fifo_data;
          next_crc     = aom_crc8(AOM_CRC_SEED, fifo_data);
          next_rd_last = 1'b0;
          next_rdr_first = (fifo_data == AOM_CMD_READ_RDR);
          if (!ctrl_enable) begin
            next_state = AOM_IDLE;
          end else if ((fifo_data == AOM_CMD_READ_MEM) || (fifo_data == AOM_CMD_READ_STAT)
                    || (fifo_data == AOM_CMD_WRITE_MEM) || (fifo_data == AOM_CMD_WRITE_STAT)
                    || ((fifo_data == AOM_CMD_READ_RDR) && (PAGES > AOM_PAGES_SMALL))) begin
            next_state = AOM_ADDR_LO;
          end else begin
            sticky_set.bad_cmd = 1'b1;
          end
        end
      end
      AOM_ADDR_LO: begin
        if (fifo_valid) begin
          fifo_take       = 1'b1;
          next_addr[7:0]  = fifo_data;
          next_crc        = aom_crc8(crc, fifo_data);
          next_state      = AOM_ADDR_HI;
        end
      end
      AOM_ADDR_HI: begin
        if (fifo_valid) begin
          fifo_take       = 1'b1;
          next_addr[15:8] = fifo_data;
          next_crc        = aom_crc8(crc, fifo_data);
          next_state      = is_write ? AOM_DATA : AOM_READ;
        end
      end
      AOM_DATA: begin
        if (!in_range) begin
          sticky_set.bad_addr = 1'b1;
          next_state          = AOM_IDLE;
        end else if (fifo_valid) begin
          fifo_take     = 1'b1;
          next_stage    = fifo_data;
          next_crc      = aom_crc8(crc, fifo_data);
          next_last_crc = aom_crc8(crc, fifo_data);
          next_tx_data  = aom_crc8(crc, fifo_data);
          next_tx_valid = 1'b1;
          next_state    = AOM_CRC_OUT;
        end
      end
      AOM_CRC_OUT: begin
        if (tx_take) begin
          next_tx_valid = 1'b0;
          next_pcnt     = '0;
          next_state    = AOM_WAIT_PULSE;
        end
      end
      AOM_WAIT_PULSE: begin
        if (prog_level) begin
          next_pcnt = PCW'(pcnt + 1'b1);
          if (int'(pcnt) == PROG_CYCLES - 1) begin
            next_tx_valid = 1'b1;
            next_state    = AOM_LAST_OUT;
            if (prot) begin
              sticky_set.rejected = 1'b1;
              next_tx_data        = cur_byte;
            end else begin
              sticky_set.committed = 1'b1;
              mem_we               = !is_status;
              stat_we              = is_status;
              next_tx_data         = prog_byte;
            end
          end
        end else begin
          next_pcnt = '0;
          // new traffic without a pulse drops the staged write
          if (fifo_valid && (pcnt == '0)) begin
            next_state = AOM_IDLE;
          end
        end
      end
      AOM_LAST_OUT: begin
        if (tx_take) begin
          next_tx_valid = 1'b0;
          next_state    = AOM_IDLE;
        end
      end
      AOM_READ: begin
        if (!in_range) begin
          sticky_set.bad_addr = 1'b1;
          next_state          = AOM_IDLE;
        end else if (!tx_valid || tx_take) begin
          next_tx_valid = 1'b1;
          if (rd_last) begin
            next_tx_data  = crc;
            next_last_crc = crc;
            next_state    = AOM_LAST_OUT;
          end else if (rdr_first) begin
            next_tx_data   = rdr_byte;
            next_crc       = aom_crc8(crc, rdr_byte);
            next_rdr_first = 1'b0;
          end else begin
            next_tx_data = cur_byte;
            next_crc     = aom_crc8(crc, cur_byte);
            next_rd_last = region_end;
            next_addr    = region_end ? addr : 16'(addr + 1'b1);
          end
        end
      end
      default: begin
        next_state = AOM_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // register port and pulse pin filter
  // ---------------------------------------------------------------------------
  always_comb begin
    next_ctrl_enable = ctrl_enable;
    next_sticky      = sticky | sticky_set;
    next_rdata       = '0;
    next_prog_level  = (prog_s2 == prog_s3) ? prog_s3 : prog_level;
    if (i_reg_write) begin
      if (i_reg_addr == AOM_REG_CTRL) begin
        next_ctrl_enable = i_reg_wdata[AOM_CTRL_ENABLE_BIT];
      end else if (i_reg_addr == AOM_REG_STATUS) begin
        // write one to clear, a same-cycle event wins
        next_sticky = (sticky & ~aom_sticky_type'(i_reg_wdata[3:0])) | sticky_set;
      end
    end
    if (i_reg_read) begin
      if (i_reg_addr == AOM_REG_CTRL) begin
        next_rdata[AOM_CTRL_ENABLE_BIT] = ctrl_enable;
      end else if (i_reg_addr == AOM_REG_STATUS) begin
        next_rdata[3:0]               = sticky;
        next_rdata[AOM_STAT_BUSY_BIT] = (state != AOM_IDLE);
        next_rdata[AOM_STAT_WAIT_BIT] = (state == AOM_WAIT_PULSE);
      end else if (i_reg_addr == AOM_REG_STAGE) begin
        next_rdata[7:0] = stage;
      end else if (i_reg_addr == AOM_REG_CRC) begin
        next_rdata[7:0] = last_crc;
      end else if (i_reg_addr == AOM_REG_ADDR) begin
        next_rdata[15:0] = addr;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      state       <= AOM_IDLE;
      sticky      <= '0;
      cmd         <= '0;
      addr        <= '0;
      stage       <= AOM_ERASED;
      crc         <= AOM_CRC_SEED;
      last_crc    <= AOM_CRC_SEED;
      tx_valid    <= 1'b0;
      tx_data     <= '0;
      rdr_first   <= 1'b0;
      rd_last     <= 1'b0;
      pcnt        <= '0;
      ctrl_enable <= AOM_CTRL_ENABLE_RST;
      rdata       <= '0;
      prog_s1     <= 1'b0;
      prog_s2     <= 1'b0;
      prog_s3     <= 1'b0;
      prog_level  <= 1'b0;
    end else begin
      state       <= next_state;
      sticky      <= next_sticky;
      cmd         <= next_cmd;
      addr        <= next_addr;
      stage       <= next_stage;
      crc         <= next_crc;
      last_crc    <= next_last_crc;
      tx_valid    <= next_tx_valid;
      tx_data     <= next_tx_data;
      rdr_first   <= next_rdr_first;
      rd_last     <= next_rd_last;
      pcnt        <= next_pcnt;
      ctrl_enable <= next_ctrl_enable;
      rdata       <= next_rdata;
      prog_s1     <= i_prog_pin;
      prog_s2     <= prog_s1;
      prog_s3     <= prog_s2;
      prog_level  <= next_prog_level;
    end
  end

  // nonvolatile array: no reset, programming only clears bits
  always_ff @(posedge i_clk) begin
    if (mem_we) begin
      data_mem[a_idx % DATA_BYTES] <= prog_byte;
    end
    if (stat_we) begin
      stat_mem[a_idx % STATUS_BYTES] <= prog_byte;
    end
  end

  assign o_reg_rdata = rdata;
  assign o_tx_valid  = tx_valid;
  assign o_tx_data   = tx_data;

endmodule

// ### aom_pkg.sv
// constants, types and checksum helper for the add-only memory block
// ---------------------------------------------------------------------------
// What this block does
// - data byte staged in one-byte register first
// - 8-bit checksum over command, address, data
// - long programming pulse commits staged byte
// - small variant: four pages of 32 bytes
// - small variant: eight status bytes, separate area
// - protected page rejects every later programming
// - bits never return erased, no erase
// - status writes use same staged sequence
// - reads stream out with checksum appended
// - mid variant: 64 pages, 88 status bytes
// - large variant: 256 pages, 352 status bytes
// - larger variants: read reporting page redirection
// - protected page locks data and redirection byte
// ---------------------------------------------------------------------------
package aom_pkg;

  // ---------------------------------------------------------------------------
  // array geometry per variant
  // ---------------------------------------------------------------------------
  localparam int AOM_PAGE_BYTES   = 32;
  localparam int AOM_PAGES_SMALL  = 4;
  localparam int AOM_STATUS_SMALL = 8;
  localparam int AOM_PAGES_MID    = 64;
  localparam int AOM_STATUS_MID   = 88;
  localparam int AOM_PAGES_LARGE  = 256;
  localparam int AOM_STATUS_LARGE = 352;
  localparam int AOM_WP_BASE      = 0;
  localparam logic [7:0] AOM_ERASED = 8'hff;

  // ---------------------------------------------------------------------------
  // link commands
  // ---------------------------------------------------------------------------
  localparam logic [7:0] AOM_CMD_READ_MEM   = 8'hf0;
  localparam logic [7:0] AOM_CMD_READ_STAT  = 8'haa;
  localparam logic [7:0] AOM_CMD_READ_RDR   = 8'ha5;
  localparam logic [7:0] AOM_CMD_WRITE_MEM  = 8'h0f;
  localparam logic [7:0] AOM_CMD_WRITE_STAT = 8'h55;

  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  localparam int AOM_CLK_PERIOD_NS = 50;
  localparam int AOM_PROG_TIME_MS  = 1;
  localparam int AOM_PROG_CYCLES   =
    (AOM_PROG_TIME_MS * 1000000 + AOM_CLK_PERIOD_NS - 1) / AOM_CLK_PERIOD_NS;

  // ---------------------------------------------------------------------------
  // buffering
  // ---------------------------------------------------------------------------
  localparam int AOM_FIFO_DEPTH = 16;
  localparam int AOM_BYTE_W     = 8;

  // ---------------------------------------------------------------------------
  // register map and fields
  // ---------------------------------------------------------------------------
  localparam logic [7:0] AOM_REG_CTRL   = 8'h00;
  localparam logic [7:0] AOM_REG_STATUS = 8'h04;
  localparam logic [7:0] AOM_REG_STAGE  = 8'h08;
  localparam logic [7:0] AOM_REG_CRC    = 8'h0c;
  localparam logic [7:0] AOM_REG_ADDR   = 8'h10;
  localparam int AOM_CTRL_ENABLE_BIT  = 0;
  localparam logic AOM_CTRL_ENABLE_RST = 1'b1;
  localparam int AOM_STAT_BUSY_BIT    = 4;
  localparam int AOM_STAT_WAIT_BIT    = 5;
  localparam logic [7:0] AOM_CRC_SEED = 8'h00;
  localparam logic [7:0] AOM_CRC_POLY = 8'h8c;

  typedef struct packed {
    logic bad_addr;
    logic bad_cmd;
    logic rejected;
    logic committed;
  } aom_sticky_type;

  typedef enum logic [3:0] {
    AOM_IDLE,
    AOM_ADDR_LO,
    AOM_ADDR_HI,
    AOM_DATA,
    AOM_CRC_OUT,
    AOM_WAIT_PULSE,
    AOM_LAST_OUT,
    AOM_READ
  } aom_state_type;

  // one byte into the reflected 8-bit checksum, low bit first
  function automatic logic [7:0] aom_crc8(input logic [7:0] crc, input logic [7:0] d);
    logic [7:0] c;
    logic       fb;
    c = crc;
    for (int i = 0; i < 8; i++) begin
      fb = c[0] ^ d[i];
      c  = {1'b0, c[7:1]};
      if (fb) begin
        c = c ^ AOM_CRC_POLY;
      end
    end
    return c;
  endfunction

endpackage

// ### aom_fifo.sv
// byte fifo between the link receiver and the command engine
`timescale 1ns/10ps
module aom_fifo
  import aom_pkg::*;
#(
  parameter int WIDTH = AOM_BYTE_W,
  parameter int DEPTH = AOM_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_reset_n,
  // filling side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // draining side
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [CW-1:0]    count;
  logic [CW-1:0]    next_count;
  logic             in_ready;
  logic             next_in_ready;
  logic             push;
  logic             pop;

  always_comb begin
    push        = i_in_valid && in_ready;
    pop         = i_out_ready && (count != '0);
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (push) begin
      next_wr_ptr = (int'(wr_ptr) == DEPTH - 1) ? '0 : AW'(wr_ptr + 1'b1);
    end
    if (pop) begin
      next_rd_ptr = (int'(rd_ptr) == DEPTH - 1) ? '0 : AW'(rd_ptr + 1'b1);
    end
    if (push && !pop) begin
      next_count = CW'(count + 1'b1);
    end else if (pop && !push) begin
      next_count = CW'(count - 1'b1);
    end
    next_in_ready = (int'(next_count) != DEPTH);
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      wr_ptr   <= '0;
      rd_ptr   <= '0;
      count    <= '0;
      in_ready <= 1'b0;
    end else begin
      wr_ptr   <= next_wr_ptr;
      rd_ptr   <= next_rd_ptr;
      count    <= next_count;
      in_ready <= next_in_ready;
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  assign o_in_ready  = in_ready;
  assign o_out_valid = (count != '0);
  assign o_out_data  = mem[rd_ptr];

endmodule

// ### aom_core_monitor.sv
// concurrent checks on the add-only memory core ports
`timescale 1ns/10ps
module aom_core_monitor
  import aom_pkg::*;
#(
  parameter int PROG_CYCLES = AOM_PROG_CYCLES
) (
  // clock and reset
  input wire logic        i_clk,
  input wire logic        i_reset_n,
  // register port
  input wire logic [7:0]  i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic        i_reg_write,
  input wire logic        i_reg_read,
  input wire logic [31:0] o_reg_rdata,
  // link
  input wire logic        o_rx_ready,
  input wire logic        o_tx_valid,
  input wire logic [7:0]  o_tx_data,
  input wire logic        i_tx_ready,
  input wire logic        i_prog_pin
);
  // ---------------------------------------------------------------------------
  // helper state: pin run length, long pulse seen, enable shadow
  // ---------------------------------------------------------------------------
  logic [15:0] run;
  logic [15:0] next_run;
  logic        long_seen;
  logic        next_long_seen;
  logic        en;
  logic        next_en;
  logic        st_rd;

  assign st_rd = i_reg_read && i_reg_addr == AOM_REG_STATUS;

  always_comb begin
    next_run       = i_prog_pin ? run + 16'h1 : 16'h0;
    next_long_seen = long_seen | (run >= PROG_CYCLES);
    next_en        = (i_reg_write && i_reg_addr == AOM_REG_CTRL) ? i_reg_wdata[0] : en;
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      run       <= 16'h0;
      long_seen <= 1'b0;
      en        <= AOM_CTRL_ENABLE_RST;
    end else begin
      run       <= next_run;
      long_seen <= next_long_seen;
      en        <= next_en;
    end
  end

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  tx_hold_a : assert property (
    o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
    else $error("tx byte dropped or changed while stalled");
  no_commit_a : assert property (
    st_rd && !long_seen |=> !o_reg_rdata[0])
    else $error("commit flagged without a full pulse");
  no_reject_a : assert property (
    st_rd && !long_seen |=> !o_reg_rdata[1])
    else $error("reject flagged without a full pulse");
  rdata_idle_a : assert property (
    !i_reg_read |=> o_reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  unmapped_zero_a : assert property (
    i_reg_read && i_reg_addr > AOM_REG_ADDR |=> o_reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  status_width_a : assert property (
    st_rd |=> o_reg_rdata[31:6] == 26'h0)
    else $error("status upper bits set");
  ctrl_value_a : assert property (
    i_reg_read && i_reg_addr == AOM_REG_CTRL |=> o_reg_rdata == {31'h0, en})
    else $error("control readback wrong");
  rx_ready_up_a : assert property (
    $rose(i_reset_n) |=> o_rx_ready)
    else $error("fifo not ready after reset");
endmodule

bind aom_core aom_core_monitor #(.PROG_CYCLES(PROG_CYCLES)) u_monitor (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .i_reg_write(i_reg_write), .i_reg_read(i_reg_read),
  .o_reg_rdata(o_reg_rdata), .o_rx_ready(o_rx_ready), .o_tx_valid(o_tx_valid),
  .o_tx_data(o_tx_data), .i_tx_ready(i_tx_ready), .i_prog_pin(i_prog_pin));

// ### aom_link_master.sv
// link-side master model: sends bytes, takes answers, drives the pulse pin
`timescale 1ns/10ps
module aom_link_master
  import aom_pkg::*;
(
  // clock
  input  wire logic       i_clk,
  // bytes to the device
  output logic            o_rx_valid,
  output logic [7:0]      o_rx_data,
  input  wire logic       i_rx_ready,
  // bytes from the device
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_data,
  output logic            o_tx_ready,
  // programming pin
  output logic            o_prog
);
  initial begin
    o_rx_valid = 1'b0;
    o_rx_data  = 8'h00;
    o_tx_ready = 1'b0;
    o_prog     = 1'b0;
  end

  // released data line shows the inverse of the last byte
  task automatic send(input logic [7:0] b);
    @(posedge i_clk);
    o_rx_valid <= 1'b1;
    o_rx_data  <= b;
    do @(posedge i_clk); while (i_rx_ready !== 1'b1);
    o_rx_valid <= 1'b0;
    o_rx_data  <= ~b;
  endtask

  task automatic recv(output logic [7:0] b, input int stall);
    repeat (stall + 1) @(posedge i_clk);
    o_tx_ready <= 1'b1;
    do @(posedge i_clk); while (i_tx_valid !== 1'b1);
    b = i_tx_data;
    o_tx_ready <= 1'b0;
  endtask

  task automatic pulse(input int n);
    @(posedge i_clk);
    o_prog <= 1'b1;
    repeat (n) @(posedge i_clk);
    o_prog <= 1'b0;
  endtask
endmodule

// ### tb_aom_core.sv
// self-checking bench for the add-only memory core
`timescale 1ns/10ps
module tb_aom_core
  import aom_pkg::*;
;
  localparam int PROG = 8;
  logic        i_clk;
  logic        i_reset_n = 1'b0;
  logic [7:0]  reg_addr  = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_write = 1'b0;
  logic        reg_read  = 1'b0;
  logic [31:0] reg_rdata;
  logic        rx_valid, rx_ready, tx_valid, tx_ready, prog;
  logic [7:0]  rx_data, tx_data, r;
  logic [7:0]  mem [128];
  logic [7:0]  st [8];
  int          fail_count = 0;
  int          checks_done = 0;

  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  aom_core #(.PROG_CYCLES(PROG)) uut (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_reg_addr(reg_addr),
    .i_reg_wdata(reg_wdata), .i_reg_write(reg_write), .i_reg_read(reg_read),
    .o_reg_rdata(reg_rdata), .i_rx_valid(rx_valid), .i_rx_data(rx_data),
    .o_rx_ready(rx_ready), .o_tx_valid(tx_valid), .o_tx_data(tx_data),
    .i_tx_ready(tx_ready), .i_prog_pin(prog));

  aom_link_master m (
    .i_clk(i_clk), .o_rx_valid(rx_valid), .o_rx_data(rx_data), .i_rx_ready(rx_ready),
    .i_tx_valid(tx_valid), .i_tx_data(tx_data), .o_tx_ready(tx_ready), .o_prog(prog));

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  function automatic logic [7:0] c8(input logic [7:0] c, input logic [7:0] d);
    for (int i = 0; i < 8; i++) c = (c[0] ^ d[i]) ? ((c >> 1) ^ 8'h8c) : (c >> 1);
    return c;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge i_clk);
    reg_write <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge i_clk);
    reg_read <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask

  // master checks the answer before it pulses
  task automatic wr_frame(input logic [7:0] cmd, input logic [15:0] a, input logic [7:0] d,
                          input logic [7:0] flip, input logic [7:0] exp);
    logic [7:0] c;
    c = c8(c8(c8(c8(8'h00, cmd), a[7:0]), a[15:8]), d);
    m.send(cmd);
    m.send(a[7:0]);
    m.send(a[15:8]);
    m.send(d ^ flip);
    m.recv(r, 0);
    chk(r === c, flip == 8'h00);
    if (r === c) begin
      m.pulse(PROG + 4);
      m.recv(r, 0);
      chk(r, exp);
    end
  endtask

  // optional fill pushes read-redirection commands, rejected by the small variant, while the answer is stalled
  task automatic rd_frame(input logic [7:0] cmd, input logic [15:0] a, input int n,
                          input int stall, input int fill);
    logic [7:0] c;
    logic [7:0] e;
    c = c8(c8(c8(8'h00, cmd), a[7:0]), a[15:8]);
    m.send(cmd);
    m.send(a[7:0]);
    m.send(a[15:8]);
    repeat (fill) m.send(AOM_CMD_READ_RDR);
    if (fill > 0) begin
      @(posedge i_clk);
      #1 chk(rx_ready, 1'b0);
    end
    for (int i = 0; i < n; i++) begin
      e = (cmd == AOM_CMD_READ_MEM) ? mem[a + i] : st[a + i];
      m.recv(r, stall);
      chk(r, e);
      c = c8(c, e);
    end
    m.recv(r, 0);
    chk(r, c);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #(50 * 40000);
    fail_count++;
    tally_and_finish;
  end

  // ---------------------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------------------
  initial begin
    for (int i = 0; i < 128; i++) mem[i] = AOM_ERASED;
    for (int i = 0; i < 8; i++) st[i] = AOM_ERASED;
    repeat (16) @(posedge i_clk);
    i_reset_n <= 1'b1;
    reg_rd(AOM_REG_CTRL, 32'h1);
    reg_rd(AOM_REG_STATUS, 32'h0);
    reg_rd(8'h14, 32'h0);
    $display("test 1 done");
    rd_frame(AOM_CMD_READ_MEM, 16'd28, 4, 0, 0);
    rd_frame(AOM_CMD_READ_MEM, 16'd126, 2, 0, 0);
    m.send(AOM_CMD_READ_MEM);
    m.send(8'h80);
    m.send(8'h00);
    repeat (4) @(posedge i_clk);
    reg_rd(AOM_REG_STATUS, 32'h8);
    reg_wr(AOM_REG_STATUS, 32'hf);
    $display("test 2 done");
    wr_frame(AOM_CMD_WRITE_MEM, 16'h25, 8'ha5, 8'h00, 8'ha5);
    reg_rd(AOM_REG_STATUS, 32'h1);
    wr_frame(AOM_CMD_WRITE_MEM, 16'h25, 8'h3c, 8'h00, 8'h24);
    mem[37] = 8'h24;
    rd_frame(AOM_CMD_READ_MEM, 16'h24, 28, 0, 0);
    $display("test 3 done");
    wr_frame(AOM_CMD_WRITE_MEM, 16'h40, 8'h00, 8'h01, 8'h00);
    reg_rd(AOM_REG_STAGE, 32'h1);
    rd_frame(AOM_CMD_READ_MEM, 16'h40, 32, 0, 0);
    reg_rd(AOM_REG_STAGE, 32'h1);
    $display("test 4 done");
    wr_frame(AOM_CMD_WRITE_STAT, 16'h1, 8'h12, 8'h00, 8'h12);
    wr_frame(AOM_CMD_WRITE_STAT, 16'h0, 8'hfd, 8'h00, 8'hfd);
    st[1] = 8'h12;
    st[0] = 8'hfd;
    reg_wr(AOM_REG_STATUS, 32'hf);
    wr_frame(AOM_CMD_WRITE_MEM, 16'h30, 8'h00, 8'h00, 8'hff);
    wr_frame(AOM_CMD_WRITE_STAT, 16'h2, 8'h00, 8'h00, 8'hff);
    reg_rd(AOM_REG_STATUS, 32'h2);
    rd_frame(AOM_CMD_READ_STAT, 16'h0, 8, 2, 0);
    $display("test 5 done");
    rd_frame(AOM_CMD_READ_MEM, 16'h7f, 1, 3, 16);
    repeat (20) @(posedge i_clk);
    reg_rd(AOM_REG_STATUS, 32'h6);
    reg_wr(AOM_REG_CTRL, 32'h0);
    reg_rd(AOM_REG_CTRL, 32'h0);
    m.send(AOM_CMD_READ_MEM);
    repeat (10) @(posedge i_clk);
    #1 chk(tx_valid, 1'b0);
    reg_wr(AOM_REG_CTRL, 32'h1);
    reg_rd(AOM_REG_CTRL, 32'h1);
    $display("test 6 done");
    tally_and_finish;
  end
endmodule
